// ### design/fpkd_map.vh
/*
  constants for the front panel keypad and display block:
  key codes, screen states, branch codes and timing counts.
  assumes a 40 MHz system clock.
*/
`ifndef FPKD_MAP_VH
`define FPKD_MAP_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FPKD_CLK_HZ 40000000
`define FPKD_DEBOUNCE_US 10
`define FPKD_DEBOUNCE_CYC ((`FPKD_CLK_HZ / 1000000) * `FPKD_DEBOUNCE_US)
`define FPKD_REPEAT_DELAY_MS 1000
`define FPKD_REPEAT_DELAY_CYC ((`FPKD_CLK_HZ / 1000) * `FPKD_REPEAT_DELAY_MS)
`define FPKD_REPEAT_RATE_HZ 15
`define FPKD_REPEAT_CYC (`FPKD_CLK_HZ / `FPKD_REPEAT_RATE_HZ)
`define FPKD_BLINK_HALF_MS 500
`define FPKD_BLINK_HALF_CYC ((`FPKD_CLK_HZ / 1000) * `FPKD_BLINK_HALF_MS)
`define FPKD_SAVER_S 38'd3600 // sized so an hour of cycles fits
`define FPKD_SAVER_CYC (`FPKD_CLK_HZ * `FPKD_SAVER_S)
`define FPKD_SCROLL_MS 250
`define FPKD_SCROLL_CYC ((`FPKD_CLK_HZ / 1000) * `FPKD_SCROLL_MS)

// ----------------------------------------
// key indices
// ----------------------------------------
`define FPKD_KEY_UP 0
`define FPKD_KEY_DOWN 1
`define FPKD_KEY_RIGHT 2
`define FPKD_KEY_LEFT 3
`define FPKD_KEY_ACCEPT 4
`define FPKD_KEY_CANCEL 5
`define FPKD_NUM_KEYS 6

// ----------------------------------------
// display geometry and cursor styles
// ----------------------------------------
`define FPKD_LINE_CHARS 24
`define FPKD_CUR_NONE 2'h0
`define FPKD_CUR_BLOCK 2'h1
`define FPKD_CUR_UNDER 2'h2

// ----------------------------------------
// screens and branches
// ----------------------------------------
`define FPKD_SCR_WELCOME 3'h0
`define FPKD_SCR_TOP 3'h1
`define FPKD_SCR_BRANCH 3'h2
`define FPKD_SCR_EDIT 3'h3
`define FPKD_SCR_SAVER 3'h4
`define FPKD_BR_CONFIG 3'h0
`define FPKD_BR_INFORMATION_BRANCH 3'h1
`define FPKD_BR_MONITOR 3'h2
`define FPKD_BR_STORE 3'h3
`define FPKD_BR_UTILITY 3'h4
`define FPKD_BR_LAST 3'h4
`define FPKD_FIELD_DIGITS 3'h4
`define FPKD_VALUE_RESET 8'h00

`endif

// ### design/fpkd_front_panel.v
/*
  front panel keypad and display controller: debounce, auto-repeat,
  menu navigation, value edit, cursor blink, screen saver.
  assumes raw active-low key pins from a membrane keypad and a
  remote-mode level from another clock domain.
*/
`timescale 1ns/1ps
`include "fpkd_map.vh"

module fpkd_front_panel #(
  parameter DEBOUNCE_CYC = `FPKD_DEBOUNCE_CYC,
  parameter REPEAT_DELAY_CYC = `FPKD_REPEAT_DELAY_CYC,
  parameter REPEAT_CYC = `FPKD_REPEAT_CYC,
  parameter BLINK_HALF_CYC = `FPKD_BLINK_HALF_CYC,
  parameter SAVER_CYC = `FPKD_SAVER_CYC,
  parameter SCROLL_CYC = `FPKD_SCROLL_CYC
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [5:0] key_pin_b,
  input wire remote_mode,
  output reg [2:0] screen,
  output reg [2:0] branch_sel,
  output reg [2:0] cursor_pos,
  output reg [1:0] cursor_style,
  output reg cursor_on,
  output reg [7:0] edit_value,
  output reg [7:0] committed_value,
  output reg commit_strobe,
  output reg edit_refused,
  output reg [4:0] scroll_offset,
  output reg [5:0] key_action
);

  // ----------------------------------------
  // key input synchronisers and debounce
  // ----------------------------------------
  reg [5:0] key_meta;
  reg [5:0] key_sync;
  reg [5:0] key_stable;
  reg [5:0] key_prev;
  reg [31:0] db_cnt [0:5];
  reg [31:0] rep_cnt [0:5];
  reg [5:0] rep_armed;
  reg [5:0] act;
  reg rm_meta;
  reg rm_sync;

  // two flops on each pin, pressed is high
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      key_meta <= 6'h00;
      key_sync <= 6'h00;
      rm_meta <= 1'b0;
      rm_sync <= 1'b0;
    end else begin
      key_meta <= ~key_pin_b;
      key_sync <= key_meta;
      rm_meta <= remote_mode;
      rm_sync <= rm_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FPKD_NUM_KEYS; gi = gi + 1) begin : g_key
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          db_cnt[gi] <= 32'h0;
          key_stable[gi] <= 1'b0;
        end else if (key_sync[gi] == key_stable[gi]) begin
          db_cnt[gi] <= 32'h0;
        end else if (db_cnt[gi] >= DEBOUNCE_CYC - 1) begin
          db_cnt[gi] <= 32'h0;
          key_stable[gi] <= key_sync[gi];
        end else begin
          db_cnt[gi] <= db_cnt[gi] + 32'h1;
        end
      end

      always @(posedge clk_sys) begin
        if (!rst_b) begin
          rep_cnt[gi] <= 32'h0;
          rep_armed[gi] <= 1'b0;
          act[gi] <= 1'b0;
          key_prev[gi] <= 1'b0;
        end else begin
          key_prev[gi] <= key_stable[gi];
          act[gi] <= 1'b0;
          if (!key_stable[gi]) begin
            rep_cnt[gi] <= 32'h0;
            rep_armed[gi] <= 1'b0;
          end else if (!key_prev[gi]) begin
            act[gi] <= 1'b1; // first action on press
            rep_cnt[gi] <= 32'h0;
          end else if (!rep_armed[gi] && rep_cnt[gi] >= REPEAT_DELAY_CYC - 1) begin
            rep_armed[gi] <= 1'b1;
            rep_cnt[gi] <= 32'h0;
            act[gi] <= 1'b1;
          end else if (rep_armed[gi] && rep_cnt[gi] >= REPEAT_CYC - 1) begin
            rep_cnt[gi] <= 32'h0;
            act[gi] <= 1'b1;
          end else begin
            rep_cnt[gi] <= rep_cnt[gi] + 32'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // display buffer
  // ----------------------------------------
  // two lines of 24 characters
  reg [7:0] text_buf [0:2*`FPKD_LINE_CHARS-1];

  // cursor limit for a screen
  function [2:0] fpkd_max_pos;
    input [2:0] scr;
    begin
      case (scr)
        `FPKD_SCR_TOP: fpkd_max_pos = `FPKD_BR_LAST;
        `FPKD_SCR_EDIT: fpkd_max_pos = `FPKD_FIELD_DIGITS - 3'h1;
        default: fpkd_max_pos = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // timers: blink, saver, scroll
  // ----------------------------------------
  reg [31:0] blink_cnt;
  reg [37:0] idle_cnt; // one hour needs 38 bits at 40 MHz
  reg [31:0] scroll_cnt;
  reg [2:0] saved_screen;
  wire any_act = |act;

  // half-second toggle gives one blink per second
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      blink_cnt <= 32'h0;
      cursor_on <= 1'b1;
    end else if (blink_cnt >= BLINK_HALF_CYC - 1) begin
      blink_cnt <= 32'h0;
      cursor_on <= ~cursor_on;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // menu state machine
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      screen <= `FPKD_SCR_WELCOME;
      saved_screen <= `FPKD_SCR_WELCOME;
      branch_sel <= `FPKD_BR_CONFIG;
      cursor_pos <= 3'h0;
      edit_value <= `FPKD_VALUE_RESET;
      committed_value <= `FPKD_VALUE_RESET;
      commit_strobe <= 1'b0;
      edit_refused <= 1'b0;
      idle_cnt <= 38'h0;
      scroll_cnt <= 32'h0;
      scroll_offset <= 5'h00;
      key_action <= 6'h00;
    end else begin
      commit_strobe <= 1'b0;
      edit_refused <= 1'b0;
      key_action <= act;
      if (any_act) begin
        idle_cnt <= 38'h0;
      end else if (idle_cnt < SAVER_CYC - 1) begin
        idle_cnt <= idle_cnt + 38'h1;
      end
      case (screen)
        `FPKD_SCR_WELCOME: begin
          if (any_act) begin
            screen <= `FPKD_SCR_TOP;
            cursor_pos <= 3'h0;
          end
        end
        `FPKD_SCR_SAVER: begin
          if (any_act) begin
            screen <= saved_screen;
          end else if (scroll_cnt >= SCROLL_CYC - 1) begin
            scroll_cnt <= 32'h0;
            if (scroll_offset == 5'd`FPKD_LINE_CHARS - 5'd1) begin
              scroll_offset <= 5'h00;
            end else begin
              scroll_offset <= scroll_offset + 5'h01;
            end
          end else begin
            scroll_cnt <= scroll_cnt + 32'h1;
          end
        end
        default: begin
          if (!any_act && idle_cnt >= SAVER_CYC - 1) begin
            saved_screen <= screen;
            screen <= `FPKD_SCR_SAVER;
            scroll_cnt <= 32'h0;
            scroll_offset <= 5'h00;
          end else begin
            if (act[`FPKD_KEY_RIGHT] && cursor_pos < fpkd_max_pos(screen)) begin
              cursor_pos <= cursor_pos + 3'h1;
            end
            if (act[`FPKD_KEY_LEFT] && cursor_pos != 3'h0) begin
              cursor_pos <= cursor_pos - 3'h1;
            end
            if (screen == `FPKD_SCR_TOP) begin
              if (act[`FPKD_KEY_ACCEPT]) begin
                branch_sel <= cursor_pos;
                screen <= `FPKD_SCR_BRANCH;
                cursor_pos <= 3'h0;
              end
            end else if (screen == `FPKD_SCR_BRANCH) begin
              if (act[`FPKD_KEY_ACCEPT]) begin
                if (branch_sel == `FPKD_BR_CONFIG && rm_sync) begin
                  edit_refused <= 1'b1;
                end else if (branch_sel == `FPKD_BR_CONFIG) begin
                  screen <= `FPKD_SCR_EDIT;
                  edit_value <= committed_value;
                  cursor_pos <= 3'h0;
                end
              end else if (act[`FPKD_KEY_CANCEL]) begin
                screen <= `FPKD_SCR_TOP;
                cursor_pos <= branch_sel;
              end
            end else if (screen == `FPKD_SCR_EDIT) begin
              if (rm_sync && (act[`FPKD_KEY_UP] || act[`FPKD_KEY_DOWN] || act[`FPKD_KEY_ACCEPT])) begin
                edit_refused <= 1'b1;
                if (act[`FPKD_KEY_ACCEPT]) begin
                  screen <= `FPKD_SCR_BRANCH;
                end
              end else if (act[`FPKD_KEY_ACCEPT]) begin
                committed_value <= edit_value;
                commit_strobe <= 1'b1;
                screen <= `FPKD_SCR_BRANCH;
                cursor_pos <= 3'h0;
              end else if (act[`FPKD_KEY_CANCEL]) begin
                edit_value <= committed_value;
                screen <= `FPKD_SCR_BRANCH;
                cursor_pos <= 3'h0;
              end else if (act[`FPKD_KEY_UP]) begin
                edit_value <= edit_value + 8'h01;
              end else if (act[`FPKD_KEY_DOWN]) begin
                edit_value <= edit_value - 8'h01;
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // cursor style
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cursor_style <= `FPKD_CUR_NONE;
    end else begin
      case (screen)
        `FPKD_SCR_EDIT: cursor_style <= `FPKD_CUR_UNDER;
        `FPKD_SCR_TOP: cursor_style <= `FPKD_CUR_BLOCK;
        `FPKD_SCR_BRANCH: cursor_style <= `FPKD_CUR_BLOCK;
        default: cursor_style <= `FPKD_CUR_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // buffer fill: blank at reset, saver text while in saver, else held
  // ----------------------------------------
  integer ci;
  // top line id, bottom status prompt
  always @(posedge clk_sys) begin
    for (ci = 0; ci < 2 * `FPKD_LINE_CHARS; ci = ci + 1) begin
      if (!rst_b) begin
        text_buf[ci] <= 8'h20;
      end else if (screen == `FPKD_SCR_SAVER) begin
        text_buf[ci] <= (ci < `FPKD_LINE_CHARS) ? 8'h49 : {7'h28, rm_sync};
      end
    end
  end

endmodule // fpkd_front_panel

// ### tb/fpkd_front_panel_assertions.sv
/*
  port assertions for the front panel block.
  assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "fpkd_map.vh"

module fpkd_front_panel_assertions #(
  parameter BLINK_HALF_CYC = 8,
  parameter SAVER_CYC = 200
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [2:0] screen,
  input wire [2:0] branch_sel,
  input wire [1:0] cursor_style,
  input wire cursor_on,
  input wire commit_strobe,
  input wire edit_refused,
  input wire [4:0] scroll_offset,
  input wire [5:0] key_action
);
  // ------
  // checks
  // ------
  reg [31:0] blink_cnt;
  reg [37:0] idle_cnt;
  // cycles since blink change and since last key action
  always @(posedge clk_sys) begin
    blink_cnt <= (!rst_b || $changed(cursor_on)) ? 32'h0 : blink_cnt + 32'h1;
    idle_cnt <= (!rst_b || key_action != 6'h00) ? 32'h0 : idle_cnt + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // accept or cancel taken while editing
  sequence s_leave_edit;
    $past(screen) == `FPKD_SCR_EDIT && key_action[5:4] != 2'h0;
  endsequence
  sequence s_in_saver;
    $past(screen) == `FPKD_SCR_SAVER && screen == `FPKD_SCR_SAVER;
  endsequence
  a_action_pulse: assert property (key_action != 6'h00 |=> key_action == 6'h00)
    else $error("key action held");
  a_welcome_exit: assert property ($past(screen) == 3'h0 && key_action != 6'h00 |-> screen == 3'h1)
    else $error("welcome not left");
  a_leave_edit: assert property (s_leave_edit |-> screen == `FPKD_SCR_BRANCH)
    else $error("edit not left");
  a_commit_cause: assert property (commit_strobe |-> key_action[4] && $past(screen) == 3'h3 ##1 !commit_strobe)
    else $error("stray commit");
  a_cancel_drop: assert property (key_action[5] |-> !commit_strobe)
    else $error("cancel committed");
  a_refuse_cause: assert property (edit_refused |-> key_action != 6'h00 && !commit_strobe)
    else $error("stray refusal");
  a_edit_under: assert property (screen == `FPKD_SCR_EDIT |=> cursor_style == `FPKD_CUR_UNDER)
    else $error("no underline");
  a_range_ok: assert property (branch_sel <= `FPKD_BR_LAST && scroll_offset < 5'h18)
    else $error("value out of range");
  a_scroll_step: assert property (s_in_saver ##0 $changed(scroll_offset) |->
    scroll_offset == ($past(scroll_offset) == 5'h17 ? 5'h00 : $past(scroll_offset) + 5'h01))
    else $error("bad scroll step");
  a_saver_idle: assert property ($rose(screen == `FPKD_SCR_SAVER) |-> idle_cnt + 3 >= SAVER_CYC)
    else $error("saver too early");
  a_blink_period: assert property (blink_cnt <= BLINK_HALF_CYC &&
    (!$changed(cursor_on) || blink_cnt + 2 >= BLINK_HALF_CYC))
    else $error("blink period wrong");
endmodule // fpkd_front_panel_assertions

bind fpkd_front_panel fpkd_front_panel_assertions #(.BLINK_HALF_CYC(BLINK_HALF_CYC), .SAVER_CYC(SAVER_CYC)) chk_u (
  .clk_sys, .rst_b, .screen, .branch_sel, .cursor_style, .cursor_on, .commit_strobe, .edit_refused,
  .scroll_offset, .key_action);

// ### tb/fpkd_operator.sv
/*
  operator model: holds one key for a set time.
  assumes pulled-up key pins, a pressed key pulls low.
*/
`timescale 1ns/1ps

module fpkd_operator (
  input wire clk_sys,
  input wire go,
  input wire [2:0] key,
  input wire [15:0] hold,
  output wire [5:0] key_pin_b,
  output wire busy
);
  // ------
  // press
  // ------
  reg [15:0] n = 16'h0000;
  reg [15:0] h = 16'h0000;
  reg [2:0] k = 3'h0;
  wire down;
  // count chatter, hold, chatter again
  always @(posedge clk_sys) begin
    if (go && n == 16'h0000) begin
      n <= hold + 16'h0006;
      h <= hold;
      k <= key;
    end else if (n != 16'h0000) begin
      n <= n - 16'h0001;
    end
  end
  assign busy = n != 16'h0000;
  // contact chatter on make and break
  assign down = busy && (n[0] || (n > 16'h0003 && n <= h + 16'h0003));
  assign key_pin_b = down ? ~(6'h01 << k) : 6'h3f;
endmodule // fpkd_operator

// ### tb/tb_fpkd_front_panel.sv
/*
  bench for the front panel block: the operator presses keys,
  a watcher checks each key action outside quiet presses against queued notes.
  assumes shortened timing parameters.
*/
`timescale 1ns/1ps
`include "fpkd_map.vh"

module tb_fpkd_front_panel;
  localparam [2:0] s_top = 3'h1, s_br = 3'h2, s_ed = 3'h3, k_up = 3'h0, k_dn = 3'h1;
  localparam [2:0] k_rt = 3'h2, k_lt = 3'h3, k_ok = 3'h4, k_no = 3'h5;
  localparam [3:0] any = 4'h8;
  reg clk_sys = 1'b0, rst_b = 1'b0, remote_mode = 1'b0, go = 1'b0, quiet = 1'b0;
  reg [2:0] key = 3'h0;
  reg [15:0] hold = 16'h0000;
  wire busy, cursor_on, commit_strobe, edit_refused;
  wire [5:0] key_pin_b, key_action;
  wire [2:0] screen, branch_sel, cursor_pos;
  wire [1:0] cursor_style;
  wire [7:0] edit_value, committed_value;
  wire [4:0] scroll_offset;
  logic [12:0] q[$];
  logic [12:0] note;
  integer errors = 0, samples_checked = 0, commits = 0, refusals = 0, cyc = 0, i, n, ups;

  fpkd_front_panel #(.DEBOUNCE_CYC(4), .REPEAT_DELAY_CYC(50), .REPEAT_CYC(10),
    .SAVER_CYC(200), .SCROLL_CYC(5)) dut_u (.clk_sys, .rst_b, .key_pin_b, .remote_mode, .screen,
    .branch_sel, .cursor_pos, .cursor_style, .cursor_on, .edit_value, .committed_value,
    .commit_strobe, .edit_refused, .scroll_offset, .key_action);
  fpkd_operator op_u (.clk_sys, .go, .key, .hold, .key_pin_b, .busy);

  // ------
  // tasks
  // ------
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task results;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  // one key press and its note; zero hold means a random short one
  task press(input [2:0] k, input [2:0] scr, input [3:0] pos, input [15:0] h = 16'h0000);
    if (!quiet) q.push_back({pos, scr, 6'h01 << k});
    @(posedge clk_sys);
    go <= 1'b1;
    key <= k;
    hold <= (h != 16'h0000) ? h : 16'h0010 + $urandom % 16;
    @(posedge clk_sys);
    go <= 1'b0;
    tick(1);
    for (n = 0; n < 200 && busy; n++) @(posedge clk_sys);
    tick(12);
  endtask

  // each key action outside quiet presses against the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (commit_strobe === 1'b1) commits = commits + 1;
    if (edit_refused === 1'b1) refusals = refusals + 1;
    if (key_action !== 6'h00 && !quiet) begin
      note = q.size() ? q.pop_front() : 13'h1fff;
      check("act", key_action, note[5:0]);
      check("scr", screen, note[8:6]);
      if (!note[12]) check("pos", cursor_pos, note[11:9]);
    end
  end
  // a hung run ends as a failure
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      results;
    end
  end

  // menu walk, edit, remote, repeat and saver
  initial begin
    void'($urandom(32'h37105f61));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    tick(1);
    check("scr", screen, 3'h0);
    check("blink", cursor_on, 1'b1);
    press(k_ok, s_top, 4'h0);
    for (i = 0; i < 5; i++) begin
      if (i > 0) press(k_rt, s_top, i);
      press(k_ok, s_br, any);
      check("branch", branch_sel, i);
      press(k_no, s_top, i);
    end
    for (i = 3; i >= 0; i--) press(k_lt, s_top, i);
    press(k_ok, s_br, any);
    press(k_ok, s_ed, any);
    ups = 2 + $urandom % 3;
    for (i = 0; i < ups; i++) press(k_up, s_ed, any);
    press(k_dn, s_ed, any);
    check("value", edit_value, ups - 1);
    press(k_ok, s_br, any);
    check("saved", committed_value, ups - 1);
    press(k_ok, s_ed, any);
    press(k_up, s_ed, any);
    press(k_no, s_br, any);
    check("saved", committed_value, ups - 1);
    check("value", edit_value, ups - 1);
    press(k_ok, s_ed, any);
    @(posedge clk_sys);
    remote_mode <= 1'b1;
    press(k_up, s_ed, any);
    press(k_ok, s_br, any);
    press(k_ok, s_br, any);
    check("refused", refusals, 3);
    check("commits", commits, 1);
    @(posedge clk_sys);
    remote_mode <= 1'b0;
    press(k_ok, s_ed, any);
    repeat (2) q.push_back({any, s_ed, 6'h01});
    press(k_up, s_ed, any, 16'h003e);
    press(k_no, s_br, any);
    check("left", q.size(), 0);
    press(k_no, s_top, 4'h0);
    tick(100);
    press(k_rt, s_top, 4'h1);
    tick(130);
    check("scr", screen, s_top);
    for (n = 0; n < 100 && screen !== `FPKD_SCR_SAVER; n++) @(posedge clk_sys);
    tick(1);
    check("scr", screen, `FPKD_SCR_SAVER);
    tick(40);
    check("scroll", scroll_offset > 5'h05 && scroll_offset < 5'h0b, 1'b1);
    quiet = 1'b1;
    press(k_up, s_top, any);
    quiet = 1'b0;
    check("scr", screen, s_top);
    check("pos", cursor_pos, 3'h1);
    results;
  end
endmodule // tb_fpkd_front_panel
